// file: design/led_boost_ldo_fault_control.sv
// Control and status logic for LED boost, regulators, power good and thermal faults
//
// Contract
// - Mode bit zero runs boost for LEDs
// - Scope bit picks all sinks or group
// - Overvoltage select: one 5.6 V, zero 18.5 V
// - Joined channel follows channel one control
// - Override bit enables backlight fade override
// - Peak limit bit picks 600 or 300 mA
// - Stop switching above rising, resume below falling
// - Open string: sink low and overvoltage
// - Open channel off alone, flag set
// - Open channel stays off until flag cleared
// - Scope one exempts independent channels from open
// - Each regulator works as load switch
// - Discharge pull-down when enabled and regulator off
// - Route bit selects regulator one power good
// - Power good rises after deglitch, drops low
// - Power good readable, route from fuse
// - Thermal limit flag follows current reduction
// - Warning bit set above warning temperature
// - Shutdown flag stops charger until cleared
// - Fault flags clear by writing one
// - Unjoined channel uses its own settings
module led_boost_ldo_fault_control
	import pmic_ctrl_pkg::*;
#(
	parameter int unsigned PG_DEGLITCH_CYC = PG_DEGLITCH_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	input wire logic fuse_pg_route_in,
	input wire logic ovp_rising_in,
	input wire logic ovp_falling_in,
	input wire logic [NUM_CH-1:0] sink_pin_low_in,
	input wire logic regulator_one_above_assert_in,
	input wire logic regulator_one_above_release_in,
	input wire logic die_over_warn_in,
	input wire logic die_over_shutdown_in,
	input wire logic charge_current_reduce_in,
	input wire logic peak_fault_in,
	input wire logic battery_short_in,
	output logic boost_mode_select_out,
	output logic boost_bias_scope_out,
	output logic overvoltage_threshold_select_out,
	output logic boost_peak_limit_select_out,
	output logic fade_override_enable_out,
	output logic boost_switching_out,
	output logic [NUM_CH-1:0] sink_on_out,
	output logic [NUM_CH*CODE_W-1:0] sink_current_out,
	output logic [3:0] fade_in_rate_code_out,
	output logic [3:0] fade_out_rate_code_out,
	output logic [3:0] sink_five_on_timer_out,
	output logic [3:0] sink_five_off_timer_out,
	output logic [NUM_LDO-1:0] regulator_on_out,
	output logic [NUM_LDO-1:0] regulator_load_switch_out,
	output logic [NUM_LDO-1:0] regulator_discharge_out,
	output logic power_good_out,
	output logic charger_enable_out
);
	// Sticky flag update: hardware set wins over a write-one clear
	function automatic logic [7:0] sticky_next(input logic [7:0] cur, input logic [7:0] set,
		input logic clr_hit, input logic [7:0] wdata);
		logic [7:0] clr;
		clr = clr_hit ? wdata : 8'h00;
		return (cur & ~clr) | set;
	endfunction

	logic [BOOST_W-1:0] boost_cfg_q;
	logic [NUM_CH-2:0] join_q;
	logic [NUM_CH-1:0] enable_q;
	logic [NUM_LDO-1:0] ldo_en_q;
	logic [NUM_LDO-1:0] ldo_dis_q;
	logic [NUM_LDO-1:0] ldo_sw_q;
	logic [NUM_CH-1:0] open_q;
	logic [7:0] fade_q;
	logic [7:0] blink_q;
	logic [CODE_W-1:0] group_code_q;
	logic [CODE_W-1:0] sink_code_q [NUM_CH-1];
	logic [FAULT_W-1:0] fault_q;
	logic route_q;
	logic fuse_loaded_q;
	logic boost_sw_q;
	logic [NUM_CH-1:0] sink_on_q;
	logic [NUM_CH*CODE_W-1:0] sink_current_q;
	logic [NUM_LDO-1:0] disch_q;
	logic pg_out_q;
	logic charger_en_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [NUM_CH-1:0] open_d;
	logic [FAULT_W-1:0] fault_d;

	pg_deglitch_if pg_link();

	// Address decode for writes
	wire wr_boost = reg_write_in && (reg_addr_in == ADDR_BOOST_CFG);
	wire wr_group = reg_write_in && (reg_addr_in == ADDR_GROUP_CFG);
	wire wr_enable = reg_write_in && (reg_addr_in == ADDR_LED_ENABLE);
	wire wr_ldo = reg_write_in && (reg_addr_in == ADDR_LDO_CFG);
	wire wr_status = reg_write_in && (reg_addr_in == ADDR_SINK_STATUS);
	wire wr_fade = reg_write_in && (reg_addr_in == ADDR_FADE_CODES);
	wire wr_blink = reg_write_in && (reg_addr_in == ADDR_BLINK_FIVE);
	wire wr_gcode = reg_write_in && (reg_addr_in == ADDR_GROUP_CODE);
	wire wr_ldo_sw = reg_write_in && (reg_addr_in == ADDR_LDO_SWITCH);
	wire wr_fault = reg_write_in && (reg_addr_in == ADDR_CHARGE_FAULT);
	wire wr_route = reg_write_in && (reg_addr_in == ADDR_PG_ROUTE);
	wire [7:0] code_offset = reg_addr_in - ADDR_SINK_CODE_BASE;
	wire wr_scode = reg_write_in && (reg_addr_in >= ADDR_SINK_CODE_BASE)
		&& (code_offset < 8'(NUM_CH - 1));

	// Configuration bit views
	wire bias_scope = boost_cfg_q[BOOST_SCOPE_BIT];
	wire led_mode = !boost_cfg_q[BOOST_MODE_BIT];

	// Channel one is the group leader; others follow it when joined
	logic [NUM_CH-1:0] sink_want;
	logic [NUM_CH-1:0] protect;
	logic [NUM_CH*CODE_W-1:0] current_d;
	always_comb begin
		sink_want[0] = enable_q[0];
		protect[0] = 1'b1;
		current_d[CODE_W-1:0] = group_code_q;
		for (int i = 1; i < NUM_CH; i++) begin
			sink_want[i] = join_q[i-1] ? enable_q[0] : enable_q[i];
			protect[i] = !(bias_scope && !join_q[i-1]);
			current_d[i*CODE_W +: CODE_W] = join_q[i-1] ? group_code_q : sink_code_q[i-1];
		end
	end

	// Open string seen: sink pin low while output at overvoltage
	wire [NUM_CH-1:0] open_detect = sink_pin_low_in & {NUM_CH{ovp_rising_in}}
		& sink_on_q & protect;

	// Open flags and charger fault flags; hardware set beats clear
	assign open_d = NUM_CH'(sticky_next(8'(open_q), 8'(open_detect), wr_status,
		reg_wdata_in));
	wire [FAULT_W-1:0] fault_set = {battery_short_in, peak_fault_in, die_over_warn_in,
		die_over_shutdown_in};
	assign fault_d = FAULT_W'(sticky_next(8'(fault_q), 8'(fault_set), wr_fault,
		reg_wdata_in));

	// Configuration registers
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boost_cfg_q <= BOOST_CFG_RST;
			join_q <= '0;
			enable_q <= '0;
			ldo_en_q <= '0;
			ldo_dis_q <= '0;
			ldo_sw_q <= '0;
			fade_q <= BYTE_RST;
			blink_q <= BYTE_RST;
			group_code_q <= '0;
		end else if (ce_in) begin
			if (wr_boost) boost_cfg_q <= reg_wdata_in[BOOST_W-1:0];
			if (wr_group) join_q <= reg_wdata_in[NUM_CH-2:0];
			if (wr_enable) enable_q <= reg_wdata_in[NUM_CH-1:0];
			if (wr_ldo) ldo_en_q <= reg_wdata_in[NUM_LDO-1:0];
			if (wr_ldo) ldo_dis_q <= reg_wdata_in[LDO_DIS_LSB +: NUM_LDO];
			if (wr_ldo_sw) ldo_sw_q <= reg_wdata_in[NUM_LDO-1:0];
			if (wr_fade) fade_q <= reg_wdata_in;
			if (wr_blink) blink_q <= reg_wdata_in;
			if (wr_gcode) group_code_q <= reg_wdata_in[CODE_W-1:0];
		end
	end

	// Independent sink current codes
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CH - 1; i++) sink_code_q[i] <= '0;
		end else if (ce_in && wr_scode) begin
			sink_code_q[code_offset[1:0]] <= reg_wdata_in[CODE_W-1:0];
		end
	end

	// Flags and fuse-loaded route bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			open_q <= '0;
			fault_q <= '0;
			route_q <= 1'b0;
			fuse_loaded_q <= 1'b0;
		end else if (ce_in) begin
			open_q <= open_d;
			fault_q <= fault_d;
			fuse_loaded_q <= 1'b1;
			if (!fuse_loaded_q) route_q <= fuse_pg_route_in;
			else if (wr_route) route_q <= reg_wdata_in[PG_REG1_BIT];
		end
	end

	// Boost switching hysteresis on the overvoltage comparator
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boost_sw_q <= 1'b0;
		end else if (ce_in) begin
			if (ovp_rising_in) boost_sw_q <= 1'b0;
			else if (ovp_falling_in) boost_sw_q <= 1'b1;
		end
	end

	// Registered outputs derived from state
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sink_on_q <= '0;
			sink_current_q <= '0;
			disch_q <= '0;
			pg_out_q <= 1'b0;
			charger_en_q <= 1'b0;
		end else if (ce_in) begin
			sink_on_q <= sink_want & ~open_q & ~open_detect;
			sink_current_q <= current_d;
			disch_q <= ldo_dis_q & ~ldo_en_q;
			pg_out_q <= route_q && pg_link.good;
			charger_en_q <= !fault_d[FAULT_SHUTDOWN_BIT] && !die_over_shutdown_in;
		end
	end

	// Power-good deglitch filter for the first regulator
	assign pg_link.enable = ldo_en_q[0];
	assign pg_link.above_assert = regulator_one_above_assert_in;
	assign pg_link.above_release = regulator_one_above_release_in;

	power_good_filter #(
		.DEGLITCH_CYCLES(PG_DEGLITCH_CYC)
	) u_pg_filter (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.pg_if(pg_link)
	);

	// Register read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			ADDR_THERMAL_STATUS: rdata_d[THERMAL_LIMIT_FLAG_BIT] = charge_current_reduce_in;
			ADDR_CHARGE_FAULT: rdata_d[FAULT_W-1:0] = fault_q;
			ADDR_PG_STATE: rdata_d[PG_REG1_BIT] = pg_link.good;
			ADDR_PG_ROUTE: rdata_d[PG_REG1_BIT] = route_q;
			ADDR_BOOST_CFG: rdata_d[BOOST_W-1:0] = boost_cfg_q;
			ADDR_GROUP_CFG: rdata_d[NUM_CH-2:0] = join_q;
			ADDR_LED_ENABLE: rdata_d[NUM_CH-1:0] = enable_q;
			ADDR_LDO_CFG: rdata_d[LDO_DIS_LSB+NUM_LDO-1:0] = {ldo_dis_q, ldo_en_q};
			ADDR_SINK_STATUS: rdata_d[NUM_CH-1:0] = open_q;
			ADDR_FADE_CODES: rdata_d = fade_q;
			ADDR_BLINK_FIVE: rdata_d = blink_q;
			ADDR_GROUP_CODE: rdata_d[CODE_W-1:0] = group_code_q;
			ADDR_LDO_SWITCH: rdata_d[NUM_LDO-1:0] = ldo_sw_q;
			default: begin
				if (wr_scode || (reg_addr_in >= ADDR_SINK_CODE_BASE
					&& code_offset < 8'(NUM_CH - 1))) begin
					rdata_d[CODE_W-1:0] = sink_code_q[code_offset[1:0]];
				end
			end
		endcase
	end

	// Read data captured on the read strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 8'h00;
		end else if (ce_in && reg_read_in) begin
			rdata_q <= rdata_d;
		end
	end

	// Output drive
	assign reg_rdata_out = rdata_q;
	assign boost_mode_select_out = boost_cfg_q[BOOST_MODE_BIT];
	assign boost_bias_scope_out = bias_scope;
	assign overvoltage_threshold_select_out = boost_cfg_q[BOOST_OVP_BIT];
	assign boost_peak_limit_select_out = boost_cfg_q[BOOST_IPK_BIT];
	assign fade_override_enable_out = boost_cfg_q[BOOST_FADE_OVERRIDE_ENABLE_BIT];
	assign boost_switching_out = boost_sw_q && (!led_mode || (|sink_on_q));
	assign sink_on_out = sink_on_q;
	assign sink_current_out = sink_current_q;
	assign fade_in_rate_code_out = fade_q[3:0];
	assign fade_out_rate_code_out = fade_q[7:4];
	assign sink_five_on_timer_out = blink_q[3:0];
	assign sink_five_off_timer_out = blink_q[7:4];
	assign regulator_on_out = ldo_en_q;
	assign regulator_load_switch_out = ldo_sw_q;
	assign regulator_discharge_out = disch_q;
	assign power_good_out = pg_out_q;
	assign charger_enable_out = charger_en_q;

	AST_OPEN_SETS_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && open_detect[0] |=> open_q[0] && !sink_on_q[0])
		else $error("Open detect did not latch flag");
	AST_OPEN_KEEPS_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && open_q[1] |=> !sink_on_q[1])
		else $error("Open channel turned back on");
	AST_OPEN_W1C: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && wr_status && reg_wdata_in[1] && !open_detect[1] |=> !open_q[1])
		else $error("Open flag not cleared by write one");
	AST_INDEP_EXEMPT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bias_scope && !join_q[3] |-> !open_detect[4])
		else $error("Independent channel flagged open under split bias");
	AST_OVP_STOPS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && ovp_rising_in |=> !boost_switching_out)
		else $error("Boost kept switching above overvoltage");
	AST_GROUP_FOLLOWS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && join_q[0] && enable_q[0] && !open_q[1] && !open_detect[1] |=> sink_on_q[1])
		else $error("Joined channel did not follow backlight");
	AST_DISCHARGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && ldo_dis_q[0] && !ldo_en_q[0] |=> regulator_discharge_out[0])
		else $error("Discharge not applied to disabled regulator");
	AST_SHUTDOWN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && die_over_shutdown_in |=> fault_q[FAULT_SHUTDOWN_BIT] && !charger_enable_out)
		else $error("Shutdown did not stop charger");
	AST_PG_ROUTE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && !route_q |=> !power_good_out)
		else $error("Power good driven while not routed");
endmodule // led_boost_ldo_fault_control

// file: design/power_good_filter.sv
// Deglitch filter for the first regulator power-good comparator
module power_good_filter
	import pmic_ctrl_pkg::*;
#(
	parameter int unsigned DEGLITCH_CYCLES = PG_DEGLITCH_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	pg_deglitch_if.filt pg_if
);
	localparam logic [PG_CNT_W-1:0] LAST_CNT = PG_CNT_W'(DEGLITCH_CYCLES - 1);

	pg_state_e state_q;
	pg_state_e state_d;
	logic [PG_CNT_W-1:0] count_q;
	logic [PG_CNT_W-1:0] count_d;

	// Count restarts whenever level drops below assert point
	always_comb begin
		state_d = state_q;
		count_d = '0;
		case (state_q)
			PG_LOW: begin
				if (pg_if.enable && pg_if.above_assert) begin
					if (count_q == LAST_CNT) begin
						state_d = PG_HIGH;
					end else begin
						count_d = count_q + 1'b1;
					end
				end
			end
			PG_HIGH: begin
				if (!pg_if.enable || !pg_if.above_release) begin
					state_d = PG_LOW;
				end
			end
			default: state_d = PG_LOW;
		endcase
	end

	// State and counter flops
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= PG_LOW;
			count_q <= '0;
		end else if (ce_in) begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	assign pg_if.good = (state_q == PG_HIGH);

	AST_PG_RISE_AFTER_COUNT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(pg_if.good) |-> $past(count_q) == LAST_CNT)
		else $error("Power good rose before full deglitch count");
	AST_PG_COUNT_RESTART: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && state_q == PG_LOW && !pg_if.above_assert |=> count_q == '0)
		else $error("Deglitch count did not restart");
	AST_PG_FALL_AT_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && pg_if.good && !pg_if.above_release |=> !pg_if.good)
		else $error("Power good did not drop at release level");
endmodule // power_good_filter

// file: dv/host_bus_model.sv
// Host processor model driving the single-byte register port
module host_bus_model (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic write_out,
	output logic read_out,
	input wire logic [7:0] rdata_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		write_out = 1'b0;
		read_out = 1'b0;
	end

	// One write strobe, raised and dropped on falling edges
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		write_out = 1'b1;
		@(negedge clk_in);
		write_out = 1'b0;
		addr_out = ~a; // Released bus shows no stale value
		wdata_out = ~d;
	endtask

	// One read strobe, data taken once the strobe edge has passed
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		read_out = 1'b1;
		@(negedge clk_in);
		read_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask
endmodule // host_bus_model

// file: dv/led_boost_ldo_fault_control_test.sv
// Self-checking bench for the LED boost, regulator and fault control block
module led_boost_ldo_fault_control_test
	import pmic_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic fuse = 1'b1;
	logic ov_r = 1'b0;
	logic ov_f = 1'b1;
	logic [4:0] pin_lo = 5'h00;
	logic pg_a = 1'b0;
	logic pg_r = 1'b0;
	logic t_w = 1'b0;
	logic t_s = 1'b0;
	logic t_l = 1'b0;
	logic pk = 1'b0;
	logic bs = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr_s, rd_s, sw, pg, chg;
	logic [4:0] bst, on, opn = 5'h00;
	logic [29:0] cur;
	logic [3:0] fi, fo, bon, boff;
	logic [2:0] r_on, r_ls, r_dis;
	int mdl [256] = '{default: 0};
	int fails = 0;
	int compares = 0;
	int unsigned seed = 55;

	// Clock at 40 MHz
	initial begin
		forever #12.5 clk = ~clk;
	end

	host_bus_model i_host_bus_model (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
		.write_out(wr_s), .read_out(rd_s), .rdata_in(rdata));

	led_boost_ldo_fault_control #(.PG_DEGLITCH_CYC(8)) i_led_boost_ldo_fault_control (
		.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(ce), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .fuse_pg_route_in(fuse), .ovp_rising_in(ov_r),
		.ovp_falling_in(ov_f), .sink_pin_low_in(pin_lo),
		.regulator_one_above_assert_in(pg_a), .regulator_one_above_release_in(pg_r),
		.die_over_warn_in(t_w), .die_over_shutdown_in(t_s),
		.charge_current_reduce_in(t_l), .peak_fault_in(pk), .battery_short_in(bs),
		.boost_mode_select_out(bst[0]), .boost_bias_scope_out(bst[1]),
		.overvoltage_threshold_select_out(bst[2]), .boost_peak_limit_select_out(bst[3]),
		.fade_override_enable_out(bst[4]), .boost_switching_out(sw), .sink_on_out(on),
		.sink_current_out(cur), .fade_in_rate_code_out(fi), .fade_out_rate_code_out(fo),
		.sink_five_on_timer_out(bon), .sink_five_off_timer_out(boff),
		.regulator_on_out(r_on), .regulator_load_switch_out(r_ls),
		.regulator_discharge_out(r_dis), .power_good_out(pg), .charger_enable_out(chg));

	// Xorshift source
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// Field masks of the modelled registers
	function automatic int msk(input logic [7:0] a);
		case (a)
			ADDR_BOOST_CFG, ADDR_LED_ENABLE, ADDR_SINK_STATUS: return 'h1f;
			ADDR_GROUP_CFG: return 'h0f;
			ADDR_LDO_CFG, ADDR_GROUP_CODE: return 'h3f;
			ADDR_FADE_CODES, ADDR_BLINK_FIVE: return 'hff;
			ADDR_LDO_SWITCH: return 'h07;
			ADDR_PG_ROUTE: return 'h01;
			default: return (a >= 8'h50 && a <= 8'h53) ? 'h3f : 0;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Write through the host and track it in the model
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host_bus_model.write_byte(a, d);
		if (ce === 1'b1) mdl[a] = d;
	endtask

	task automatic rdv(input logic [7:0] a, input int m, input int e);
		logic [7:0] v;
		i_host_bus_model.read_byte(a, v);
		chk(v & m, e & m);
	endtask

	// Compare every configuration output with the model
	task automatic chk_out();
		logic [4:0] on_e;
		logic [29:0] cur_e;
		logic g;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 5; i++) begin
			g = (i == 0) || mdl[ADDR_GROUP_CFG][i - 1];
			on_e[i] = (g ? mdl[ADDR_LED_ENABLE][0] : mdl[ADDR_LED_ENABLE][i]) & ~opn[i];
			cur_e[6 * i +: 6] = g ? 6'(mdl[ADDR_GROUP_CODE]) : 6'(mdl[ADDR_SINK_CODE_BASE + i - 1]);
		end
		chk(on, on_e);
		chk(cur, cur_e);
		chk(bst, mdl[ADDR_BOOST_CFG] & 'h1f);
		chk({fo, fi}, mdl[ADDR_FADE_CODES]);
		chk({boff, bon}, mdl[ADDR_BLINK_FIVE]);
		chk(r_on, mdl[ADDR_LDO_CFG] & 7);
		chk(r_ls, mdl[ADDR_LDO_SWITCH] & 7);
		chk(r_dis, (mdl[ADDR_LDO_CFG] >> 3) & ~mdl[ADDR_LDO_CFG] & 7);
	endtask

	task automatic end_of_test();
		if (fails == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#(25 * 20000);
		fails++;
		end_of_test();
	end

	// Main sequence
	initial begin
		mdl[ADDR_PG_ROUTE] = 1;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		for (int a = 'h40; a < 'h54; a++) begin
			rdv(8'(a), 'hff, 0);
		end
		rdv(ADDR_CHARGE_FAULT, 'hff, 0);
		rdv(ADDR_PG_ROUTE, 'h01, 1);
		wr(8'h7f, 8'hff);
		rdv(8'h7f, 'hff, 0);
		chk(chg, 1'b1);
		for (int b = 0; b < 6; b++) begin
			wr(ADDR_BOOST_CFG, b < 5 ? 8'(1 << b) : rnd() & 8'h1f);
			chk_out();
		end
		repeat (4) begin
			wr(ADDR_BOOST_CFG, rnd() & 8'h1e);
			wr(ADDR_GROUP_CFG, rnd() & 8'h0f);
			wr(ADDR_GROUP_CODE, rnd() & 8'h3f);
			for (int c = 0; c < 4; c++) begin
				wr(ADDR_SINK_CODE_BASE + 8'(c), rnd() & 8'h3f);
			end
			wr(ADDR_FADE_CODES, rnd());
			wr(ADDR_BLINK_FIVE, rnd());
			wr(ADDR_LDO_CFG, rnd() & 8'h3f);
			wr(ADDR_LDO_SWITCH, rnd() & 8'h07);
			wr(ADDR_LED_ENABLE, rnd() & 8'h1f);
			chk_out();
		end
		for (int a = 'h40; a < 'h54; a++) begin
			rdv(8'(a), msk(8'(a)), mdl[a]);
		end
		// Write with the clock enable low is ignored
		ce = 1'b0;
		wr(ADDR_GROUP_CODE, ~mdl[ADDR_GROUP_CODE]);
		ce = 1'b1;
		rdv(ADDR_GROUP_CODE, 'h3f, mdl[ADDR_GROUP_CODE]);
		// Open string on a joined channel, hysteresis of switching
		wr(ADDR_BOOST_CFG, 8'h00);
		wr(ADDR_GROUP_CFG, 8'h01);
		wr(ADDR_LED_ENABLE, 8'h11);
		chk_out();
		chk(sw, 1'b1);
		ov_f = 1'b0;
		ov_r = 1'b1;
		pin_lo = 5'h02;
		opn = 5'h02;
		repeat (3) @(negedge clk);
		chk(sw, 1'b0);
		ov_r = 1'b0;
		pin_lo = 5'h00;
		chk_out();
		chk(sw, 1'b0);
		rdv(ADDR_SINK_STATUS, 'h1f, opn);
		wr(ADDR_SINK_STATUS, 8'h02);
		opn = 5'h00;
		ov_f = 1'b1;
		chk_out();
		chk(sw, 1'b1);
		// Scope one: independent channel five is exempt
		wr(ADDR_BOOST_CFG, 8'h02);
		ov_f = 1'b0;
		ov_r = 1'b1;
		pin_lo = 5'h13;
		opn = 5'h03;
		repeat (3) @(negedge clk);
		ov_r = 1'b0;
		pin_lo = 5'h00;
		chk_out();
		rdv(ADDR_SINK_STATUS, 'h1f, opn);
		wr(ADDR_SINK_STATUS, 8'h1f);
		opn = 5'h00;
		ov_f = 1'b1;
		chk_out();
		// Power-good deglitch and routing
		wr(ADDR_LDO_CFG, 8'h01);
		pg_r = 1'b1;
		pg_a = 1'b1;
		repeat (6) @(negedge clk);
		chk(pg, 1'b0);
		pg_a = 1'b0;
		@(negedge clk);
		pg_a = 1'b1;
		repeat (6) @(negedge clk);
		chk(pg, 1'b0);
		repeat (6) @(negedge clk);
		chk(pg, 1'b1);
		rdv(ADDR_PG_STATE, 'h01, 1);
		wr(ADDR_PG_ROUTE, 8'h00);
		@(negedge clk);
		chk(pg, 1'b0);
		wr(ADDR_PG_ROUTE, 8'h01);
		@(negedge clk);
		chk(pg, 1'b1);
		pg_r = 1'b0;
		pg_a = 1'b0;
		repeat (3) @(negedge clk);
		chk(pg, 1'b0);
		// Thermal and charger faults
		t_l = 1'b1;
		rdv(ADDR_THERMAL_STATUS, 'h10, 'h10);
		t_l = 1'b0;
		rdv(ADDR_THERMAL_STATUS, 'h10, 0);
		t_w = 1'b1;
		pk = 1'b1;
		bs = 1'b1;
		@(negedge clk);
		t_w = 1'b0;
		pk = 1'b0;
		bs = 1'b0;
		rdv(ADDR_CHARGE_FAULT, 'h0f, 'h0e);
		wr(ADDR_CHARGE_FAULT, 8'h06);
		rdv(ADDR_CHARGE_FAULT, 'h0f, 'h08);
		t_s = 1'b1;
		repeat (2) @(negedge clk);
		chk(chg, 1'b0);
		wr(ADDR_CHARGE_FAULT, 8'h09);
		rdv(ADDR_CHARGE_FAULT, 'h0f, 'h01);
		t_s = 1'b0;
		repeat (2) @(negedge clk);
		chk(chg, 1'b0);
		wr(ADDR_CHARGE_FAULT, 8'h01);
		repeat (2) @(negedge clk);
		chk(chg, 1'b1);
		rdv(ADDR_CHARGE_FAULT, 'h0f, 0);
		// Second reset with the fuse default cleared
		fuse = 1'b0;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		rdv(ADDR_PG_ROUTE, 'h01, 0);
		rdv(ADDR_SINK_STATUS, 'h1f, 0);
		chk(chg, 1'b1);
		end_of_test();
	end
endmodule // led_boost_ldo_fault_control_test

// file: include/pg_deglitch_if.sv
// Signals between the control block and the power-good deglitch filter
interface pg_deglitch_if;
	logic enable;
	logic above_assert;
	logic above_release;
	logic good;
	modport ctrl (output enable, output above_assert, output above_release, input good);
	modport filt (input enable, input above_assert, input above_release, output good);
endinterface

// file: include/pmic_ctrl_pkg.sv
// Shared constants and types for the LED boost, regulator and fault control block
package pmic_ctrl_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_THERMAL_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CHARGE_FAULT = 8'h0a;
	localparam logic [7:0] ADDR_PG_STATE = 8'h36;
	localparam logic [7:0] ADDR_PG_ROUTE = 8'h37;
	localparam logic [7:0] ADDR_BOOST_CFG = 8'h40;
	localparam logic [7:0] ADDR_GROUP_CFG = 8'h41;
	localparam logic [7:0] ADDR_LED_ENABLE = 8'h42;
	localparam logic [7:0] ADDR_LDO_CFG = 8'h43;
	localparam logic [7:0] ADDR_SINK_STATUS = 8'h44;
	localparam logic [7:0] ADDR_FADE_CODES = 8'h45;
	localparam logic [7:0] ADDR_BLINK_FIVE = 8'h46;
	localparam logic [7:0] ADDR_GROUP_CODE = 8'h47;
	localparam logic [7:0] ADDR_LDO_SWITCH = 8'h48;
	localparam logic [7:0] ADDR_SINK_CODE_BASE = 8'h50;
	// Field positions
	localparam int THERMAL_LIMIT_FLAG_BIT = 4;
	localparam int FAULT_SHUTDOWN_BIT = 0;
	localparam int FAULT_WARN_BIT = 1;
	localparam int FAULT_PEAK_BIT = 2;
	localparam int FAULT_SHORT_BIT = 3;
	localparam int PG_REG1_BIT = 0;
	localparam int BOOST_MODE_BIT = 0;
	localparam int BOOST_SCOPE_BIT = 1;
	localparam int BOOST_OVP_BIT = 2;
	localparam int BOOST_IPK_BIT = 3;
	localparam int BOOST_FADE_OVERRIDE_ENABLE_BIT = 4;
	localparam int LDO_DIS_LSB = 3;
	// Widths
	localparam int NUM_CH = 5;
	localparam int NUM_LDO = 3;
	localparam int CODE_W = 6;
	localparam int FAULT_W = 4;
	localparam int BOOST_W = 5;
	// Reset values
	localparam logic [BOOST_W-1:0] BOOST_CFG_RST = 5'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Power-good deglitch timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned PG_DEGLITCH_NS = 2000000;
	localparam int unsigned PG_DEGLITCH_CYCLES = (PG_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PG_CNT_W = 17;
	// Power-good filter states
	typedef enum logic [0:0] {
		PG_LOW = 1'b0,
		PG_HIGH = 1'b1
	} pg_state_e;
endpackage
